// ### design/pvm_params.svh
`ifndef PVM_PARAMS_SVH
`define PVM_PARAMS_SVH
// ==========================================
// bus geometry
`define PVM_ADDR_W 8
`define PVM_DATA_W 8
// ==========================================
// byte register indexes (addr[3:0], addr[7:4] zero)
`define PVM_OFS_PORT 4'h0
`define PVM_OFS_DIR 4'h1
`define PVM_OFS_B_IN 4'h2
`define PVM_OFS_B_OUT 4'h3
`define PVM_OFS_B_DIR 4'h4
`define PVM_OFS_C_IN 4'h5
`define PVM_OFS_C_OUT 4'h6
`define PVM_OFS_C_DIR 4'h7
`define PVM_OFS_FIX_OUT 4'h8
`define PVM_OFS_COPY 4'h9
`define PVM_OFS_PTR 4'ha
`define PVM_OFS_AT_PTR 4'hb
`define PVM_OFS_AT_INC 4'hc
`define PVM_OFS_AT_DEC 4'hd
// ==========================================
// bit space: addr[7] set, addr[6:3] index, addr[2:0] bit
`define PVM_BIT_SPACE_POS 7
// ==========================================
// implemented bit masks per variant
`define PVM_EP_IN 8'h1e
`define PVM_EP_OUT 8'h17
`define PVM_EP_DIR 8'h16
`define PVM_FS_IN 8'h1f
`define PVM_FS_OUT 8'h3f
`define PVM_FL_IN 8'hff
`define PVM_FL_OUT 8'hff
`define PVM_LG_IN 8'hc7
`define PVM_LG_OUT 8'hff
`define PVM_DP_ALL 8'hff
`define PVM_NONE 8'h00
// ==========================================
// reset values and sizes
`define PVM_RST_BYTE 8'h00
`define PVM_SCR_DEPTH 128
`endif

// ### design/pvm_pkg.sv
`include "pvm_params.svh"
package pvm_pkg;
	typedef enum logic [2:0] {
		PVM_EIGHT_PIN,
		PVM_FIXED_SMALL,
		PVM_FIXED_LARGE,
		PVM_LEGACY,
		PVM_DUAL_PORT
	} pvm_variant_e;
	typedef enum logic [1:0] {
		PVM_STEP_NONE,
		PVM_STEP_INC,
		PVM_STEP_DEC
	} pvm_step_e;
	typedef logic [`PVM_DATA_W-1:0] pvm_byte_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`PVM_ADDR_W-1:0] addr;
		pvm_byte_t wdata;
	} pvm_req_s;
	typedef struct packed {
		pvm_byte_t out;
		pvm_byte_t oe;
	} pvm_pins_s;
endpackage : pvm_pkg

// ### design/pvm_port_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "pvm_params.svh"
module pvm_port_bank #(
	parameter logic [7:0] IN_MASK = `PVM_FL_IN,
	parameter logic [7:0] OUT_MASK = `PVM_FL_OUT,
	parameter logic [7:0] DIR_MASK = `PVM_NONE
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire pvm_pkg::pvm_byte_t pin_in,
	input wire logic wr_out,
	input wire logic wr_dir,
	input wire logic copy,
	input wire pvm_pkg::pvm_byte_t bit_en,
	input wire pvm_pkg::pvm_byte_t wbyte,
	output pvm_pkg::pvm_byte_t in_lvl,
	output pvm_pkg::pvm_byte_t dir,
	output pvm_pkg::pvm_pins_s drv
);
	import pvm_pkg::*;
	pvm_byte_t out_ff;
	pvm_byte_t dir_ff;
	genvar gi;
	// ==========================================
	// per-bit latches
	for (gi = 0; gi < 8; gi++)
	begin : g_bit
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				out_ff[gi] <= 1'b0;
			else if (copy)
				out_ff[gi] <= pin_in[gi] & OUT_MASK[gi];
			else if (wr_out && bit_en[gi])
				out_ff[gi] <= wbyte[gi] & OUT_MASK[gi];
		end
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				dir_ff[gi] <= 1'b0;
			else if (wr_dir && bit_en[gi])
				dir_ff[gi] <= wbyte[gi] & DIR_MASK[gi];
		end
	end
	assign in_lvl = pin_in & IN_MASK;
	assign dir = dir_ff;
	assign drv.out = out_ff;
	assign drv.oe = (OUT_MASK & ~DIR_MASK) | (dir_ff & DIR_MASK);
endmodule : pvm_port_bank
`default_nettype wire

// ### design/pvm_scratch.sv
`timescale 1ns/100ps
`default_nettype none
`include "pvm_params.svh"
module pvm_scratch #(
	parameter int DEPTH = `PVM_SCR_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ptr_wr,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire pvm_pkg::pvm_step_e step,
	input wire pvm_pkg::pvm_byte_t wdata,
	output pvm_pkg::pvm_byte_t ptr,
	output pvm_pkg::pvm_byte_t rd_byte
);
	import pvm_pkg::*;
	localparam int AW = $clog2(DEPTH);
	pvm_byte_t ptr_ff;
	pvm_byte_t mem_ff [DEPTH];
	logic [AW-1:0] idx;
	genvar gi;
	// index wraps at the depth; upper pointer bits are ignored
	assign idx = ptr_ff[AW-1:0];
	// ==========================================
	// pointer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ptr_ff <= `PVM_RST_BYTE;
		else if (ptr_wr)
			ptr_ff <= wdata;
		else if ((acc_wr || acc_rd) && step == PVM_STEP_INC)
			ptr_ff <= ptr_ff + 8'h01;
		else if ((acc_wr || acc_rd) && step == PVM_STEP_DEC)
			ptr_ff <= ptr_ff - 8'h01;
	end
	for (gi = 0; gi < DEPTH; gi++)
	begin : g_mem
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				mem_ff[gi] <= `PVM_RST_BYTE;
			else if (acc_wr && idx == AW'(gi))
				mem_ff[gi] <= wdata;
		end
	end
	assign ptr = ptr_ff;
	assign rd_byte = mem_ff[idx];
endmodule : pvm_scratch
`default_nettype wire

// ### design/pvm_top.sv
// Notes on behaviour
// - A byte write to the port drives every output pin from its bit.
// - A port read returns the input pin levels sampled at the read.
// - Copying the port to itself loads input levels into the outputs.
// - The eight-pin variant has direction bits only at 4, 2 and 1.
// - Each direction bit makes its pin a driven output or an input.
// - Small fixed variant inputs are bits 4..0; large has all eight.
// - Small fixed variant outputs are bits 5..0; large has all eight.
// - Legacy variant inputs are bits 7, 6, 2, 1 and 0 only.
// - Dual port variant has own input, output and direction for B, C.
// - The byte pointer selects scratch data and steps after an increment or decrement access.
// - Each implemented input bit reads on its own as one bit.
// - Each output bit writes alone, other outputs keep their level.
// - Each direction bit writes alone, others keep their value.
`timescale 1ns/100ps
`default_nettype none
`include "pvm_params.svh"
module pvm_top #(
	parameter pvm_pkg::pvm_variant_e VARIANT = pvm_pkg::PVM_DUAL_PORT,
	parameter int SCR_DEPTH = `PVM_SCR_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire pvm_pkg::pvm_req_s req,
	output pvm_pkg::pvm_byte_t rdata,
	input wire pvm_pkg::pvm_byte_t port_a_in,
	input wire pvm_pkg::pvm_byte_t port_b_in,
	input wire pvm_pkg::pvm_byte_t port_c_in,
	output pvm_pkg::pvm_pins_s port_a_drv,
	output pvm_pkg::pvm_pins_s port_b_drv,
	output pvm_pkg::pvm_pins_s port_c_drv
);
	import pvm_pkg::*;
	localparam bit DUAL = (VARIANT == PVM_DUAL_PORT);

	// ==========================================
	// implemented masks
	function automatic pvm_byte_t in_mask(input int p);
		pvm_byte_t a;
		a = `PVM_NONE;
		case (VARIANT)
			PVM_EIGHT_PIN: a = `PVM_EP_IN;
			PVM_FIXED_SMALL: a = `PVM_FS_IN;
			PVM_FIXED_LARGE: a = `PVM_FL_IN;
			PVM_LEGACY: a = `PVM_LG_IN;
			default: a = `PVM_NONE;
		endcase
		if (DUAL)
			return (p == 0) ? `PVM_NONE : `PVM_DP_ALL;
		return (p == 0) ? a : `PVM_NONE;
	endfunction : in_mask

	function automatic pvm_byte_t out_mask(input int p);
		pvm_byte_t a;
		a = `PVM_NONE;
		case (VARIANT)
			PVM_EIGHT_PIN: a = `PVM_EP_OUT;
			PVM_FIXED_SMALL: a = `PVM_FS_OUT;
			PVM_FIXED_LARGE: a = `PVM_FL_OUT;
			PVM_LEGACY: a = `PVM_LG_OUT;
			default: a = `PVM_NONE;
		endcase
		if (DUAL)
			return (p == 0) ? `PVM_NONE : `PVM_DP_ALL;
		return (p == 0) ? a : `PVM_NONE;
	endfunction : out_mask

	function automatic pvm_byte_t dir_mask(input int p);
		if (VARIANT == PVM_EIGHT_PIN)
			return (p == 0) ? `PVM_EP_DIR : `PVM_NONE;
		if (DUAL)
			return (p == 0) ? `PVM_NONE : `PVM_DP_ALL;
		return `PVM_NONE;
	endfunction : dir_mask

	// ==========================================
	// reset release
	logic [1:0] rst_ff;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_ff <= 2'b00;
		else
			rst_ff <= {rst_ff[0], 1'b1};
	end
	assign rst_n = rst_ff[1];

	// ==========================================
	// decode
	logic bit_acc;
	logic byte_acc;
	logic [3:0] idx;
	logic [2:0] bsel;
	pvm_byte_t bit_en;
	pvm_byte_t wbyte;
	logic [15:0] wr_hit;
	assign bit_acc = req.addr[`PVM_BIT_SPACE_POS];
	assign byte_acc = (req.addr[7:4] == 4'h0);
	assign idx = bit_acc ? req.addr[6:3] : req.addr[3:0];
	assign bsel = req.addr[2:0];
	assign bit_en = bit_acc ? (8'h01 << bsel) : 8'hff;
	assign wbyte = bit_acc ? {8{req.wdata[0]}} : req.wdata;
	always_comb
	begin
		wr_hit = 16'h0000;
		if (req.wr && (bit_acc || byte_acc))
			wr_hit[idx] = 1'b1;
	end

	// ==========================================
	// port banks
	pvm_byte_t pin_in [3];
	pvm_byte_t in_lvl [3];
	pvm_byte_t dir [3];
	pvm_pins_s drv [3];
	logic [2:0] wr_out;
	logic [2:0] wr_dir;
	logic [2:0] copy;
	assign pin_in[0] = port_a_in;
	assign pin_in[1] = port_b_in;
	assign pin_in[2] = port_c_in;
	assign wr_out[0] = wr_hit[`PVM_OFS_PORT] | wr_hit[`PVM_OFS_FIX_OUT];
	assign wr_out[1] = wr_hit[`PVM_OFS_B_OUT];
	assign wr_out[2] = wr_hit[`PVM_OFS_C_OUT];
	assign wr_dir[0] = wr_hit[`PVM_OFS_DIR];
	assign wr_dir[1] = wr_hit[`PVM_OFS_B_DIR];
	assign wr_dir[2] = wr_hit[`PVM_OFS_C_DIR];
	assign copy = {3{wr_hit[`PVM_OFS_COPY]}} & bit_en[2:0] & wbyte[2:0];

	genvar gp;
	for (gp = 0; gp < 3; gp++)
	begin : g_bank
		pvm_port_bank #(
			.IN_MASK(in_mask(gp)),
			.OUT_MASK(out_mask(gp)),
			.DIR_MASK(dir_mask(gp))
		) u_bank (
			.clk(ref_clk),
			.rst_n(rst_n),
			.pin_in(pin_in[gp]),
			.wr_out(wr_out[gp]),
			.wr_dir(wr_dir[gp]),
			.copy(copy[gp]),
			.bit_en(bit_en),
			.wbyte(wbyte),
			.in_lvl(in_lvl[gp]),
			.dir(dir[gp]),
			.drv(drv[gp])
		);
	end
	assign port_a_drv = drv[0];
	assign port_b_drv = drv[1];
	assign port_c_drv = drv[2];

	// ==========================================
	// scratchpad, dual port variant only
	pvm_step_e step;
	pvm_byte_t ptr;
	pvm_byte_t scr_byte;
	logic acc_hit;
	logic acc_rd;
	always_comb
	begin
		case (req.addr[3:0])
			`PVM_OFS_AT_INC: step = PVM_STEP_INC;
			`PVM_OFS_AT_DEC: step = PVM_STEP_DEC;
			default: step = PVM_STEP_NONE;
		endcase
	end
	// indirect forms are byte wide only; a bit access would step twice
	assign acc_hit = DUAL && byte_acc && req.addr[3:0] >= `PVM_OFS_AT_PTR
		&& req.addr[3:0] <= `PVM_OFS_AT_DEC;
	assign acc_rd = acc_hit && req.rd;

	pvm_scratch #(
		.DEPTH(SCR_DEPTH)
	) u_scratch (
		.clk(ref_clk),
		.rst_n(rst_n),
		.ptr_wr(DUAL && wr_hit[`PVM_OFS_PTR]),
		.acc_wr(acc_hit && req.wr),
		.acc_rd(acc_rd),
		.step(step),
		.wdata(req.wdata),
		.ptr(ptr),
		.rd_byte(scr_byte)
	);

	// ==========================================
	// read path
	pvm_byte_t rd_val;
	pvm_byte_t rdata_ff;
	always_comb
	begin
		case (idx)
			// live pin levels at the read
			`PVM_OFS_PORT: rd_val = in_lvl[0];
			`PVM_OFS_DIR: rd_val = dir[0];
			`PVM_OFS_B_IN: rd_val = in_lvl[1];
			`PVM_OFS_B_DIR: rd_val = dir[1];
			`PVM_OFS_C_IN: rd_val = in_lvl[2];
			`PVM_OFS_C_DIR: rd_val = dir[2];
			`PVM_OFS_PTR: rd_val = DUAL ? ptr : `PVM_NONE;
			`PVM_OFS_AT_PTR,
			`PVM_OFS_AT_INC,
			`PVM_OFS_AT_DEC: rd_val = (DUAL && !bit_acc) ? scr_byte : `PVM_NONE;
			default: rd_val = `PVM_NONE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= `PVM_RST_BYTE;
		else if (req.rd && bit_acc)
			rdata_ff <= {7'h00, rd_val[bsel]};
		else if (req.rd && byte_acc)
			rdata_ff <= rd_val;
		else
			rdata_ff <= `PVM_RST_BYTE;
	end
	assign rdata = rdata_ff;

	// ==========================================
	// checks
	pvm_req_s req_q_ff;
	pvm_byte_t pa_q_ff;
	pvm_byte_t outa_q_ff;
	pvm_byte_t outc_q_ff;
	pvm_byte_t dira_q_ff;
	pvm_byte_t ptr_q_ff;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_q_ff <= '0;
			pa_q_ff <= `PVM_RST_BYTE;
			outa_q_ff <= `PVM_RST_BYTE;
			outc_q_ff <= `PVM_RST_BYTE;
			dira_q_ff <= `PVM_RST_BYTE;
			ptr_q_ff <= `PVM_RST_BYTE;
		end
		else
		begin
			req_q_ff <= req;
			pa_q_ff <= port_a_in;
			outa_q_ff <= drv[0].out;
			outc_q_ff <= drv[2].out;
			dira_q_ff <= dir[0];
			ptr_q_ff <= ptr;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	AST_BYTE_OUT:
	assert property (req.wr && req.addr == 8'h00 |=>
		drv[0].out == (req_q_ff.wdata & out_mask(0)))
		else $error("port byte write not on outputs");
	AST_PORT_READ:
	assert property (req.rd && req.addr == 8'h00 |=>
		rdata == (pa_q_ff & in_mask(0)))
		else $error("port read not sampled pin levels");
	AST_COPY:
	assert property (req.wr && req.addr == 8'h09 && req.wdata[0] |=>
		drv[0].out == (pa_q_ff & out_mask(0)))
		else $error("copy did not load inputs");
	AST_DIR_MASK:
	assert property ((dir[0] & ~dir_mask(0)) == `PVM_NONE)
		else $error("direction bit outside allowed set");
	AST_OE_B:
	assert property (req.wr && req.addr == 8'h04 |=>
		port_b_drv.oe == (req_q_ff.wdata & dir_mask(1)))
		else $error("port b enable not from direction");
	AST_IN_MASK:
	assert property (req.rd && req.addr == 8'h00 |=>
		(rdata & ~in_mask(0)) == `PVM_NONE)
		else $error("absent input bit read high");
	AST_OUT_MASK:
	assert property ((drv[0].out & ~out_mask(0)) == `PVM_NONE)
		else $error("absent output bit driven");
	AST_LEGACY_IN:
	assert property (VARIANT == PVM_LEGACY && req.rd && req.addr == 8'h00
		|=> rdata[5:3] == 3'h0)
		else $error("legacy input bits 5..3 not zero");
	AST_B_APART:
	assert property (req.wr && req.addr == 8'h03 |=>
		port_c_drv.out == outc_q_ff)
		else $error("port b write disturbed port c");
	AST_PTR_INC:
	assert property (DUAL && req.rd && req.addr == 8'h0c |=>
		ptr == ptr_q_ff + 8'h01)
		else $error("pointer did not advance by one");
	AST_PTR_DEC:
	assert property (DUAL && req.wr && req.addr == 8'h0d |=>
		ptr == ptr_q_ff - 8'h01)
		else $error("pointer did not drop by one");
	AST_BIT_READ:
	assert property (req.rd && req.addr[7:3] == 5'h10 |=>
		rdata == (((pa_q_ff & in_mask(0)) >> req_q_ff.addr[2:0])
		& 8'h01))
		else $error("bit read wrong");
	AST_BIT_OUT:
	assert property (req.wr && req.addr[7:3] == 5'h10 |=>
		((drv[0].out ^ outa_q_ff) & ~(8'h01 << req_q_ff.addr[2:0]))
		== `PVM_NONE)
		else $error("bit write changed other outputs");
	AST_BIT_DIR:
	assert property (req.wr && req.addr[7:3] == 5'h11 |=>
		((dir[0] ^ dira_q_ff) & ~(8'h01 << req_q_ff.addr[2:0]))
		== `PVM_NONE)
		else $error("bit write changed other directions");
	AST_UNMAPPED:
	assert property (req.rd && req.addr == 8'h0f ##1 1 |-> rdata == 8'h00)
		else $error("unmapped read not zero");

	COV_BYTE_WR: cover property (req.wr && req.addr == 8'h00);
	COV_BIT_RD: cover property (req.rd && bit_acc ##1 rdata[0]);
	COV_PTR_INC: cover property (acc_rd && step == PVM_STEP_INC);
	COV_COPY: cover property (copy != 3'h0);
endmodule : pvm_top
`default_nettype wire

// ### verification/port_variable_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pvm_params.svh"
module port_variable_map_tb;
	import pvm_pkg::*;
	// ==========================================
	// clock, stimulus and reference model
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	pvm_req_s req = '0;
	pvm_byte_t ext [3];
	pvm_byte_t rdata, ep_rdata, rv, ev, lvl_a, lvl_b, lvl_c, ep_lvl;
	pvm_pins_s a_drv, b_drv, c_drv, ep_drv, pv;
	pvm_byte_t fs_rdata, fl_rdata, lg_rdata;
	pvm_pins_s fs_drv, fl_drv, lg_drv;
	int seed = 36184;
	int error_cnt = 0;
	int checked = 0;
	logic [7:0] out_m [3];
	logic [7:0] dir_m [3];
	logic [7:0] mem [128];
	int ptr_m;
	logic [7:0] d, eo;
	always #2.5 ref_clk = ~ref_clk;
	// ==========================================
	// instances
	pvm_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
		.rdata(rdata), .port_a_in(lvl_a), .port_b_in(lvl_b),
		.port_c_in(lvl_c), .port_a_drv(a_drv), .port_b_drv(b_drv),
		.port_c_drv(c_drv));
	pvm_top #(.VARIANT(PVM_EIGHT_PIN)) dut_ep (.ref_clk(ref_clk),
		.reset_n(reset_n), .req(req), .rdata(ep_rdata),
		.port_a_in(ep_lvl), .port_b_in(8'h00), .port_c_in(8'h00),
		.port_a_drv(ep_drv), .port_b_drv(), .port_c_drv());
	// fixed and legacy variants have separate input pins, fed straight from outside
	pvm_top #(.VARIANT(PVM_FIXED_SMALL)) dut_fs (.ref_clk(ref_clk),
		.reset_n(reset_n), .req(req), .rdata(fs_rdata),
		.port_a_in(ext[0]), .port_b_in(8'h00), .port_c_in(8'h00),
		.port_a_drv(fs_drv), .port_b_drv(), .port_c_drv());
	pvm_top #(.VARIANT(PVM_FIXED_LARGE)) dut_fl (.ref_clk(ref_clk),
		.reset_n(reset_n), .req(req), .rdata(fl_rdata),
		.port_a_in(ext[0]), .port_b_in(8'h00), .port_c_in(8'h00),
		.port_a_drv(fl_drv), .port_b_drv(), .port_c_drv());
	pvm_top #(.VARIANT(PVM_LEGACY)) dut_lg (.ref_clk(ref_clk),
		.reset_n(reset_n), .req(req), .rdata(lg_rdata),
		.port_a_in(ext[0]), .port_b_in(8'h00), .port_c_in(8'h00),
		.port_a_drv(lg_drv), .port_b_drv(), .port_c_drv());
	pvm_pin_model pin_a (.drv(a_drv), .ext(ext[0]), .lvl(lvl_a));
	pvm_pin_model pin_b (.drv(b_drv), .ext(ext[1]), .lvl(lvl_b));
	pvm_pin_model pin_c (.drv(c_drv), .ext(ext[2]), .lvl(lvl_c));
	pvm_pin_model pin_e (.drv(ep_drv), .ext(ext[0]), .lvl(ep_lvl));
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] wd);
		@(posedge ref_clk);
		req <= '{w, r, a, wd};
		@(posedge ref_clk);
		req <= '0;
		#1;
		rv = rdata;
		ev = ep_rdata;
	endtask : xfer
	function automatic logic [7:0] ba(input int idx, input int b);
		return {1'b1, idx[3:0], b[2:0]};
	endfunction : ba
	function automatic logic [7:0] lv(input int p);
		return (out_m[p] & dir_m[p]) | (ext[p] & ~dir_m[p]);
	endfunction : lv
	task automatic complete_run;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	// ==========================================
	// watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		complete_run();
	end
	// ==========================================
	// main sequence
	initial
	begin
		foreach (ext[i]) ext[i] = 8'h00;
		foreach (out_m[i]) out_m[i] = 8'h00;
		foreach (dir_m[i]) dir_m[i] = 8'h00;
		foreach (mem[i]) mem[i] = 8'h00;
		ptr_m = 0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("b_out_rst", b_drv.out, 8'h00);
		chk("c_oe_rst", c_drv.oe, 8'h00);
		chk("ep_oe_rst", ep_drv.oe, `PVM_EP_OUT & ~`PVM_EP_DIR);
		for (int p = 1; p < 3; p++)
		begin
			@(posedge ref_clk);
			ext[p] <= 8'($random(seed));
			d = 8'($random(seed));
			xfer(1'b1, 1'b0, 8'(3 * p + 1), d);
			dir_m[p] = d;
			d = 8'($random(seed));
			xfer(1'b1, 1'b0, 8'(3 * p), d);
			out_m[p] = d;
			pv = (p == 1) ? b_drv : c_drv;
			chk("out_byte", pv.out, out_m[p]);
			chk("oe_byte", pv.oe, dir_m[p]);
			xfer(1'b0, 1'b1, 8'(3 * p + 1), 8'h00);
			chk("dir_rd", rv, dir_m[p]);
			xfer(1'b0, 1'b1, 8'(3 * p), 8'h00);
			chk("out_rd", rv, 8'h00);
			xfer(1'b0, 1'b1, 8'(3 * p - 1), 8'h00);
			chk("in_rd", rv, lv(p));
			for (int b = 0; b < 8; b++)
			begin
				d = 8'($random(seed));
				xfer(1'b1, 1'b0, ba(3 * p, b), {7'h00, d[0]});
				out_m[p][b] = d[0];
				d = 8'($random(seed));
				xfer(1'b1, 1'b0, ba(3 * p + 1, b), {7'h00, d[1]});
				dir_m[p][b] = d[1];
				xfer(1'b0, 1'b1, ba(3 * p - 1, b), 8'h00);
				d = lv(p);
				chk("in_bit", rv, {7'h00, d[b]});
				pv = (p == 1) ? b_drv : c_drv;
				chk("out_bit", pv.out, out_m[p]);
				chk("dir_bit", pv.oe, dir_m[p]);
			end
		end
		// the copy takes the levels present at the write edge
		out_m[1] = lv(1);
		out_m[2] = lv(2);
		xfer(1'b1, 1'b0, 8'h09, 8'h06);
		chk("copy_b", b_drv.out, out_m[1]);
		chk("copy_c", c_drv.out, out_m[2]);
		@(posedge ref_clk);
		ext[0] <= 8'($random(seed));
		xfer(1'b1, 1'b0, 8'h00, 8'hc3);
		chk("a_out", a_drv.out, 8'h00);
		chk("ep_out", ep_drv.out, 8'hc3 & `PVM_EP_OUT);
		chk("fs_out", fs_drv.out, 8'hc3 & `PVM_FS_OUT);
		chk("fl_out", fl_drv.out, 8'hc3);
		chk("lg_out", lg_drv.out, 8'hc3);
		for (int k = 0; k < 2; k++)
		begin
			eo = ep_drv.oe;
			xfer(1'b0, 1'b1, 8'h00, 8'h00);
			d = ((8'hc3 & `PVM_EP_OUT & eo) | (ext[0] & ~eo)) & `PVM_EP_IN;
			chk("ep_in", ev, d);
			chk("a_in", rv, 8'h00);
			chk("fs_in", fs_rdata, ext[0] & `PVM_FS_IN);
			chk("fl_in", fl_rdata, ext[0]);
			chk("lg_in", lg_rdata, ext[0] & `PVM_LG_IN);
			xfer(1'b1, 1'b0, 8'h01, 8'hff);
		end
		xfer(1'b0, 1'b1, 8'h01, 8'h00);
		chk("ep_dir", ev, `PVM_EP_DIR);
		chk("a_dir", rv, 8'h00);
		d = (`PVM_EP_OUT & ~`PVM_EP_DIR) | `PVM_EP_DIR;
		chk("ep_oe", ep_drv.oe, d);
		xfer(1'b1, 1'b0, 8'h08, 8'h5a);
		chk("ep_alias", ep_drv.out, 8'h5a & `PVM_EP_OUT);
		chk("fs_alias", fs_drv.out, 8'h5a & `PVM_FS_OUT);
		d = ext[0];
		xfer(1'b0, 1'b1, ba(0, 4), 8'h00);
		chk("lg_bit4", lg_rdata, 8'h00);
		chk("fl_bit4", fl_rdata, {7'h00, d[4]});
		xfer(1'b1, 1'b0, 8'h09, 8'h01);
		chk("fs_copy", fs_drv.out, ext[0] & `PVM_FS_OUT);
		chk("lg_copy", lg_drv.out, ext[0]);
		xfer(1'b1, 1'b0, 8'h0f, 8'hff);
		xfer(1'b1, 1'b0, 8'h40, 8'hff);
		xfer(1'b0, 1'b1, 8'h0f, 8'h00);
		chk("unmapped", rv, 8'h00);
		chk("b_keep", b_drv.out, out_m[1]);
		ptr_m = 120;
		xfer(1'b1, 1'b0, 8'h0a, 8'(ptr_m));
		for (int k = 0; k < 3; k++)
		begin
			d = 8'($random(seed));
			xfer(1'b1, 1'b0, 8'h0c, d);
			mem[ptr_m] = d;
			ptr_m++;
		end
		xfer(1'b0, 1'b1, 8'h0a, 8'h00);
		chk("ptr_inc", rv, 8'(ptr_m));
		ptr_m = 120;
		xfer(1'b1, 1'b0, 8'h0a, 8'(ptr_m));
		xfer(1'b0, 1'b1, 8'h0b, 8'h00);
		chk("at_ptr", rv, mem[ptr_m]);
		xfer(1'b0, 1'b1, 8'h0c, 8'h00);
		chk("at_inc0", rv, mem[ptr_m]);
		ptr_m++;
		xfer(1'b0, 1'b1, 8'h0c, 8'h00);
		chk("at_inc1", rv, mem[ptr_m]);
		ptr_m++;
		xfer(1'b0, 1'b1, 8'h0d, 8'h00);
		chk("at_dec", rv, mem[ptr_m]);
		ptr_m--;
		xfer(1'b0, 1'b1, 8'h0b, 8'h00);
		chk("at_after", rv, mem[ptr_m]);
		// read data stand one cycle only
		@(posedge ref_clk);
		#1;
		chk("rd_idle", rdata, 8'h00);
		xfer(1'b0, 1'b1, 8'h0a, 8'h00);
		chk("ptr_dec", rv, 8'(ptr_m));
		d = 8'($random(seed));
		xfer(1'b1, 1'b0, 8'h0d, d);
		mem[ptr_m] = d;
		ptr_m--;
		xfer(1'b0, 1'b1, 8'h0a, 8'h00);
		chk("ptr_wdec", rv, 8'(ptr_m));
		xfer(1'b0, 1'b1, 8'h0c, 8'h00);
		chk("at_wdec0", rv, mem[ptr_m]);
		ptr_m++;
		xfer(1'b0, 1'b1, 8'h0b, 8'h00);
		chk("at_wdec1", rv, mem[ptr_m]);
		complete_run();
	end
endmodule : port_variable_map_tb
`default_nettype wire

// ### verification/pvm_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module pvm_pin_model (
	input wire pvm_pkg::pvm_pins_s drv,
	input wire pvm_pkg::pvm_byte_t ext,
	output pvm_pkg::pvm_byte_t lvl
);
	import pvm_pkg::*;
	// ==========================================
	// pin levels seen by the block
	// driven pins follow
	// undriven pins take the outside level, never the stale latch
	assign lvl = (drv.out & drv.oe) | (ext & ~drv.oe);
endmodule : pvm_pin_model
`default_nettype wire
